/* verilog/are_engine.sv */
// are_engine: read-family command engine behind the task-file registers.
// assumes: host strobes synchronous to mclk, media answers each request.
// What this block does
// - accept c4h as multiple read; block size one always, larger optional
// - multiple read interrupts once per block, when data request rises
// - data request checked at block start; data kept up through block
// - count is total sectors; full blocks, then count mod block size
// - multiple read with no block size programmed is aborted
// - media error posted when the failing sector is acked; block still transferred
// - only corrected errors (18) and code 01 let later blocks continue
// - 20h/21h read 1 to 256 sectors; zero count means 256
// - address bytes map to lba bits; drive/head bits 7 and 5 read one
// - per sector: busy; at ack data request, clear busy, interrupt; then fill
// - on success the address registers hold the last sector read
// - on error stop at failing sector, address kept, data still readable
// - 40h/41h verify with busy, no data request, one final interrupt
// - verify error leaves failing address and unverified count
// - any 1xh is recalibrate, a plain no-op
// - 03h returns the previous extended error code in error register
// - general extended codes 00 01 09 20 21 2f
// - data path codes 11 18 1f
// - media codes 10 14 3a 03 22
// - self test, format and voltage code groups
// - hard reset, and soft reset without keep_settings, leave multiple reads disabled until a block size is loaded
`timescale 1ns/1ps
`default_nettype none

module are_engine #(
  parameter int          SECTOR_WORDS = 256,
  parameter int          FIFO_DEPTH   = 4,
  parameter logic [7:0]  MAX_BLOCK    = 8'h10,
  parameter logic [27:0] LAST_LBA     = 28'hfffffff
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // host task-file port
  input  wire logic [2:0]  host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [15:0] host_wdata,
  output logic [15:0]      host_rdata,
  output logic             host_wait,
  output logic             intrq,
  // block size and soft reset from the rest of the card
  input  wire logic        mult_load,
  input  wire logic [7:0]  mult_size,
  input  wire logic        soft_reset,
  input  wire logic        keep_settings,
  // media side
  output logic             med_req,
  output logic [27:0]      med_lba,
  output logic             med_stream,
  input  wire logic        med_ack,
  input  wire logic [7:0]  med_err,
  input  wire logic        med_valid,
  output logic             med_ready,
  input  wire logic [15:0] med_data
);

  localparam int WW = $clog2(SECTOR_WORDS);
  localparam logic [WW-1:0] WORD_LAST = WW'(SECTOR_WORDS - 1);

  // unknown media codes fold into the miscellaneous code
  function automatic logic [7:0] legal_code(input logic [7:0] c);
    legal_code = are_pkg::EXT_MISC;
    if (c >= are_pkg::EXT_DIAG_LO && c <= are_pkg::EXT_DIAG_HI) legal_code = c;
    case (c)
      are_pkg::EXT_NONE, are_pkg::EXT_SELF_OK, are_pkg::EXT_BAD_CMD,
      are_pkg::EXT_BAD_ADDR, are_pkg::EXT_OVERFLOW: legal_code = c;
      are_pkg::EXT_UNCORR, are_pkg::EXT_CORR, are_pkg::EXT_ABORT: legal_code = c;
      are_pkg::EXT_IDNF_A, are_pkg::EXT_IDNF_B, are_pkg::EXT_SPARE_OUT,
      are_pkg::EXT_WR_FAIL, are_pkg::EXT_PWR1_OFF: legal_code = c;
      are_pkg::EXT_DIAG_A, are_pkg::EXT_DIAG_B, are_pkg::EXT_DIAG_C,
      are_pkg::EXT_FMT_A, are_pkg::EXT_FMT_B, are_pkg::EXT_FMT_C,
      are_pkg::EXT_FMT_D, are_pkg::EXT_FMT_E,
      are_pkg::EXT_VOLT_A, are_pkg::EXT_VOLT_B: legal_code = c;
      default: ;
    endcase
  endfunction

  // error register bits for an extended code
  function automatic logic [7:0] err_bits(input logic [7:0] c);
    err_bits = 8'h00;
    case (c)
      are_pkg::EXT_NONE, are_pkg::EXT_SELF_OK, are_pkg::EXT_CORR: ;
      are_pkg::EXT_UNCORR: err_bits[are_pkg::ER_UNC] = 1'b1;
      are_pkg::EXT_IDNF_A, are_pkg::EXT_IDNF_B, are_pkg::EXT_BAD_ADDR,
      are_pkg::EXT_OVERFLOW: err_bits[are_pkg::ER_IDNF] = 1'b1;
      are_pkg::EXT_FMT_A, are_pkg::EXT_FMT_B, are_pkg::EXT_FMT_C,
      are_pkg::EXT_FMT_D, are_pkg::EXT_FMT_E: err_bits[are_pkg::ER_AMNF] = 1'b1;
      default: err_bits[are_pkg::ER_ABRT] = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  are_pkg::are_state_t state_q;
  logic [27:0]   lba_q;
  logic [3:0]    dh_q;
  logic [8:0]    remain_q;
  logic [7:0]    block_q;
  logic [7:0]    blk_left_q;
  logic [WW-1:0] word_q;
  logic          busy_q;
  logic          drq_q;
  logic          intr_q;
  logic          ver_q;
  logic          mult_q;
  logic          stop_q;
  logic          req_q;
  logic [7:0]    ext_q;
  logic [7:0]    err_reg_q;
  logic          err_st_q;
  logic          corr_q;
  logic [15:0]   rdata_q;
  logic          fifo_ov;
  logic [15:0]   fifo_od;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire       st_idle  = state_q == are_pkg::ST_IDLE;
  wire       st_ack   = state_q == are_pkg::ST_ACK;
  wire       st_xfer  = state_q == are_pkg::ST_XFER;
  wire [7:0] code     = host_wdata[7:0];
  wire       tf_wr    = host_wr && st_idle && !busy_q;
  wire       wr_cmd   = tf_wr && host_addr == are_pkg::REG_CMD_STAT;
  wire       rd_stat  = host_rd && host_addr == are_pkg::REG_CMD_STAT;
  wire       pop_req  = host_rd && host_addr == are_pkg::REG_DATA && drq_q;
  wire       pop      = pop_req && fifo_ov;
  wire       c_mult   = code == are_pkg::CMD_READ_MULT;
  wire       c_rd     = c_mult || code == are_pkg::CMD_READ_SEC
                        || code == are_pkg::CMD_READ_SECR;
  wire       c_ver    = code == are_pkg::CMD_VERIFY || code == are_pkg::CMD_VERIFYR;
  wire       c_recal  = code[7:4] == are_pkg::CMD_RECAL_HI;
  wire       c_sense  = code == are_pkg::CMD_SENSE;
  wire       mult_off = c_mult && block_q == 8'h00;
  wire [28:0] lba_end = {1'b0, lba_q} + {20'h00000, remain_q} - 29'h0000001;
  wire       range_bad = (c_rd || c_ver) && lba_end > {1'b0, LAST_LBA};
  wire       start_med = (c_rd || c_ver) && !mult_off && !range_bad;
  wire       sec_last = remain_q == 9'h001;
  wire [7:0] ack_code = legal_code(med_err);
  wire       ack      = st_ack && med_ack;
  wire       fatal    = ack_code != are_pkg::EXT_NONE && ack_code != are_pkg::EXT_CORR
                        && ack_code != are_pkg::EXT_SELF_OK;
  wire       err_new  = ack && ack_code != are_pkg::EXT_NONE && !stop_q;
  wire       sect_done = st_xfer && pop && word_q == WORD_LAST;
  wire       rd_end   = sec_last || (stop_q && blk_left_q == 8'h01);
  wire [7:0] eff_blk  = mult_q ? block_q : 8'h01;
  wire [7:0] new_blk  = (remain_q < {1'b0, eff_blk}) ? remain_q[7:0] : eff_blk;
  wire       ver_step = ack && ver_q && !fatal;
  wire       dec      = ver_step || sect_done;
  wire       inc      = (ver_step && !sec_last) || (sect_done && !sec_last && !stop_q);
  wire       new_blk_ack = ack && !ver_q && blk_left_q == 8'h00;
  wire       ver_end  = ack && ver_q && (fatal || sec_last);
  wire       intr_set = new_blk_ack || ver_end || (wr_cmd && !start_med);
  wire       flush    = soft_reset || wr_cmd;

  wire [7:0] status = {busy_q, !busy_q, 1'b0, 1'b1, drq_q, corr_q, 1'b0, err_st_q};
  wire [7:0] reg8   = (host_addr == are_pkg::REG_FEAT_ERR) ? err_reg_q :
                      (host_addr == are_pkg::REG_SEC_CNT)  ? remain_q[7:0] :
                      (host_addr == are_pkg::REG_SEC_NUM)  ? lba_q[7:0] :
                      (host_addr == are_pkg::REG_CYL_LO)   ? lba_q[15:8] :
                      (host_addr == are_pkg::REG_CYL_HI)   ? lba_q[23:16] :
                      (host_addr == are_pkg::REG_DRV_HEAD) ? {dh_q | are_pkg::DH_ONES, lba_q[27:24]} :
                      status;
  wire [15:0] rd_mux = (host_addr == are_pkg::REG_DATA) ? fifo_od : {8'h00, reg8};

  assign host_rdata = rdata_q;
  assign host_wait  = drq_q && !fifo_ov;
  assign intrq      = intr_q;
  assign med_req    = req_q;
  assign med_lba    = lba_q;
  assign med_stream = !ver_q;

  ////////////////////////////////////////////////////////////////////////////
  // data path: media words wait here until the host strobes them out

  are_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .flush     (flush),
    .in_valid  (med_valid),
    .in_ready  (med_ready),
    .in_data   (med_data),
    .out_valid (fifo_ov),
    .out_ready (pop_req),
    .out_data  (fifo_od)
  );

  ////////////////////////////////////////////////////////////////////////////
  // task-file registers; host writes only while idle

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lba_q    <= '0;
      dh_q     <= are_pkg::DH_ONES;
      remain_q <= are_pkg::SEC_CNT_RST;
      rdata_q  <= '0;
    end else begin
      if (host_rd) rdata_q <= rd_mux;
      if (tf_wr) begin
        case (host_addr)
          are_pkg::REG_SEC_CNT:  remain_q <= (code == 8'h00) ? are_pkg::SEC_CNT_ZERO : {1'b0, code};
          are_pkg::REG_SEC_NUM:  lba_q[7:0] <= code;
          are_pkg::REG_CYL_LO:   lba_q[15:8] <= code;
          are_pkg::REG_CYL_HI:   lba_q[23:16] <= code;
          are_pkg::REG_DRV_HEAD: begin
            lba_q[27:24] <= code[3:0];
            dh_q         <= code[7:4];
          end
          default: ;
        endcase
      end else begin
        if (dec) remain_q <= remain_q - 9'h001;
        if (inc) lba_q <= lba_q + 28'h0000001;
      end
    end
  end

  // block size: only sizes up to the supported maximum enable multiple reads
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) block_q <= 8'h00;
    else if (soft_reset && !keep_settings) block_q <= 8'h00;
    else if (mult_load) block_q <= (mult_size <= MAX_BLOCK) ? mult_size : 8'h00;
  end

  // set beats the clearing status read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) intr_q <= 1'b0;
    else if (soft_reset) intr_q <= 1'b0;
    else intr_q <= intr_set || (intr_q && !rd_stat && !wr_cmd);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) word_q <= '0;
    else if (flush) word_q <= '0;
    else if (pop) word_q <= word_q + WW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // error and extended code

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_q     <= are_pkg::EXT_NONE;
      err_reg_q <= 8'h00;
      err_st_q  <= 1'b0;
      corr_q    <= 1'b0;
    end else if (wr_cmd) begin
      corr_q   <= 1'b0;
      err_st_q <= !(c_sense || c_recal || start_med);
      if (c_sense) begin
        err_reg_q <= ext_q;
        ext_q     <= are_pkg::EXT_NONE;
      end else if (mult_off) begin
        ext_q     <= are_pkg::EXT_ABORT;
        err_reg_q <= err_bits(are_pkg::EXT_ABORT);
      end else if (range_bad) begin
        ext_q     <= are_pkg::EXT_OVERFLOW;
        err_reg_q <= err_bits(are_pkg::EXT_OVERFLOW);
      end else if (start_med || c_recal) begin
        ext_q     <= are_pkg::EXT_NONE;
        err_reg_q <= 8'h00;
      end else begin
        ext_q     <= are_pkg::EXT_BAD_CMD;
        err_reg_q <= err_bits(are_pkg::EXT_BAD_CMD);
      end
    end else if (err_new) begin
      ext_q     <= ack_code;
      err_reg_q <= err_bits(ack_code);
      err_st_q  <= fatal;
      corr_q    <= !fatal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= are_pkg::ST_IDLE;
      busy_q     <= 1'b0;
      drq_q      <= 1'b0;
      ver_q      <= 1'b0;
      mult_q     <= 1'b0;
      stop_q     <= 1'b0;
      req_q      <= 1'b0;
      blk_left_q <= 8'h00;
    end else if (soft_reset) begin
      state_q <= are_pkg::ST_IDLE;
      busy_q  <= 1'b0;
      drq_q   <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (state_q)
        are_pkg::ST_IDLE: if (wr_cmd && start_med) begin
          state_q    <= are_pkg::ST_REQ;
          busy_q     <= 1'b1;
          ver_q      <= c_ver;
          mult_q     <= c_mult;
          stop_q     <= 1'b0;
          blk_left_q <= 8'h00;
        end
        are_pkg::ST_REQ: begin
          req_q   <= 1'b1;
          state_q <= are_pkg::ST_ACK;
        end
        are_pkg::ST_ACK: if (med_ack) begin
          if (ver_q) begin
            state_q <= ver_end ? are_pkg::ST_IDLE : are_pkg::ST_REQ;
            busy_q  <= !ver_end;
          end else begin
            state_q <= are_pkg::ST_XFER;
            if (fatal) stop_q <= 1'b1;
            if (blk_left_q == 8'h00) begin
              drq_q      <= 1'b1;
              busy_q     <= 1'b0;
              blk_left_q <= new_blk;
            end
          end
        end
        are_pkg::ST_XFER: if (sect_done) begin
          if (rd_end) begin
            state_q <= are_pkg::ST_IDLE;
            drq_q   <= 1'b0;
            busy_q  <= 1'b0;
          end else begin
            state_q    <= are_pkg::ST_REQ;
            blk_left_q <= blk_left_q - 8'h01;
            if (blk_left_q == 8'h01) begin
              drq_q  <= 1'b0;
              busy_q <= 1'b1;
            end
          end
        end
        default: state_q <= are_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n || soft_reset);

  a_mult_abort: assert property (wr_cmd && c_mult && block_q == 8'h00 |=>
    !busy_q && err_st_q && intr_q && st_idle) else $error("multiple read not aborted");
  a_block_intr: assert property (new_blk_ack |=> drq_q && intr_q && !busy_q)
    else $error("block start without request and interrupt");
  a_no_mid_intr: assert property (drq_q && $past(drq_q) |-> !$rose(intr_q))
    else $error("interrupt raised inside a block");
  a_drq_held: assert property (sect_done && blk_left_q > 8'h01 && !rd_end |=> drq_q)
    else $error("data request dropped inside a block");
  a_zero_count: assert property (tf_wr && host_addr == are_pkg::REG_SEC_CNT && code == 8'h00
    |=> remain_q == 9'h100) else $error("zero count not taken as 256");
  a_verify_quiet: assert property (ver_q && !st_idle |-> !drq_q && !med_stream)
    else $error("verify raised data request");
  a_recal_nop: assert property (wr_cmd && c_recal |=> st_idle && intr_q && !err_st_q
    ##1 !req_q) else $error("recalibrate not a no-op");
  a_sense_code: assert property (wr_cmd && c_sense |=> err_reg_q == $past(ext_q))
    else $error("sense code not returned");
  a_addr_freeze: assert property (sect_done && stop_q |=> lba_q == $past(lba_q))
    else $error("address moved past failing sector");
  a_last_sector: assert property (sect_done && sec_last |=> st_idle && !drq_q && remain_q == 9'h000)
    else $error("read did not end on last sector");

endmodule // are_engine

`default_nettype wire

/* verilog/are_pkg.sv */
// are_pkg: task-file offsets, command codes, status and error fields,
// extended error codes, reset values and the engine state type.
// assumes: used as are_pkg::name by the read command engine.
package are_pkg;

  // task-file register offsets
  localparam logic [2:0] REG_DATA      = 3'h0;
  localparam logic [2:0] REG_FEAT_ERR  = 3'h1;
  localparam logic [2:0] REG_SEC_CNT   = 3'h2;
  localparam logic [2:0] REG_SEC_NUM   = 3'h3;
  localparam logic [2:0] REG_CYL_LO    = 3'h4;
  localparam logic [2:0] REG_CYL_HI    = 3'h5;
  localparam logic [2:0] REG_DRV_HEAD  = 3'h6;
  localparam logic [2:0] REG_CMD_STAT  = 3'h7;

  // command codes
  localparam logic [7:0] CMD_READ_MULT = 8'hc4;
  localparam logic [7:0] CMD_READ_SEC  = 8'h20;
  localparam logic [7:0] CMD_READ_SECR = 8'h21;
  localparam logic [7:0] CMD_VERIFY    = 8'h40;
  localparam logic [7:0] CMD_VERIFYR   = 8'h41;
  localparam logic [3:0] CMD_RECAL_HI  = 4'h1;
  localparam logic [7:0] CMD_SENSE     = 8'h03;

  // status and error register bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  localparam int ER_AMNF = 0;

  // drive/head bits 7 and 5 always read as one
  localparam logic [3:0] DH_ONES       = 4'ha;
  localparam logic [8:0] SEC_CNT_RST   = 9'h001;
  localparam logic [8:0] SEC_CNT_ZERO  = 9'h100;

  // extended error codes
  localparam logic [7:0] EXT_NONE      = 8'h00;
  localparam logic [7:0] EXT_SELF_OK   = 8'h01;
  localparam logic [7:0] EXT_MISC      = 8'h09;
  localparam logic [7:0] EXT_BAD_CMD   = 8'h20;
  localparam logic [7:0] EXT_BAD_ADDR  = 8'h21;
  localparam logic [7:0] EXT_OVERFLOW  = 8'h2f;
  localparam logic [7:0] EXT_UNCORR    = 8'h11;
  localparam logic [7:0] EXT_CORR      = 8'h18;
  localparam logic [7:0] EXT_ABORT     = 8'h1f;
  localparam logic [7:0] EXT_IDNF_A    = 8'h10;
  localparam logic [7:0] EXT_IDNF_B    = 8'h14;
  localparam logic [7:0] EXT_SPARE_OUT = 8'h3a;
  localparam logic [7:0] EXT_WR_FAIL   = 8'h03;
  localparam logic [7:0] EXT_PWR1_OFF  = 8'h22;
  localparam logic [7:0] EXT_DIAG_A    = 8'h05;
  localparam logic [7:0] EXT_DIAG_LO   = 8'h30;
  localparam logic [7:0] EXT_DIAG_HI   = 8'h34;
  localparam logic [7:0] EXT_DIAG_B    = 8'h37;
  localparam logic [7:0] EXT_DIAG_C    = 8'h3e;
  localparam logic [7:0] EXT_FMT_A     = 8'h0c;
  localparam logic [7:0] EXT_FMT_B     = 8'h38;
  localparam logic [7:0] EXT_FMT_C     = 8'h3b;
  localparam logic [7:0] EXT_FMT_D     = 8'h3c;
  localparam logic [7:0] EXT_FMT_E     = 8'h3f;
  localparam logic [7:0] EXT_VOLT_A    = 8'h35;
  localparam logic [7:0] EXT_VOLT_B    = 8'h36;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_ACK, ST_XFER} are_state_t;

endpackage

/* verilog/are_fifo.sv */
// are_fifo: small word fifo between media stream and host data register.
// assumes: single clock, DEPTH a power of two, flush empties it at once.
`timescale 1ns/1ps
`default_nettype none

module are_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset; empty state hides stale words
  always_ff @(posedge mclk) begin
    if (push) mem_q[wp_q] <= in_data;
  end

endmodule // are_fifo

`default_nettype wire

/* verification/are_media_model.sv */
// are_media_model: media side of the read engine, one ack then words.
// assumes: engine raises med_req for one cycle, one request at a time.
`timescale 1ns/1ps
`default_nettype none
module are_media_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // engine requests
  input  wire logic        med_req,
  input  wire logic [27:0] med_lba,
  input  wire logic        med_stream,
  // answers
  output logic             med_ack,
  output logic [7:0]       med_err,
  output logic             med_valid,
  input  wire logic        med_ready,
  output logic [15:0]      med_data,
  // fault and pace set by the bench
  input  wire logic [27:0] err_lba,
  input  wire logic [7:0]  err_code,
  input  wire logic [3:0]  dly
);
  logic [27:0] lba;
  logic        s;
  logic        r;
  int          i;
  initial begin
    med_ack = 0; med_err = 8'h00; med_valid = 0; med_data = 16'h0000;
    forever begin
      @(posedge mclk);
      if (med_req && reset_n) begin
        lba = med_lba;
        s = med_stream;
        repeat (dly) @(posedge mclk);
        med_ack <= 1;
        med_err <= (lba == err_lba) ? err_code : 8'h00;
        @(posedge mclk);
        med_ack <= 0;
        med_err <= ~med_err;
        // released lines show the inverted last value, not the last word
        for (i = 0; s && i < 256; ) begin
          med_valid <= 1;
          med_data  <= {lba[7:0], i[7:0]};
          @(negedge mclk) r = med_ready;
          @(posedge mclk);
          if (r) i++;
        end
        med_valid <= 0;
        med_data  <= ~med_data;
      end
    end
  end
endmodule // are_media_model
`default_nettype wire

/* verification/tb_top.sv */
// tb_top: host-side bench for are_engine with a media model.
// assumes: task-file access protocol of the engine, 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic mclk, reset_n, host_wr, host_rd, mult_load, soft_reset, keep_settings, host_wait, intrq;
  logic med_req, med_stream, med_ack, med_valid, med_ready;
  logic [2:0] host_addr;
  logic [15:0] host_wdata, host_rdata, med_data, d;
  logic [7:0] mult_size, med_err, err_code;
  logic [27:0] med_lba, err_lba;
  logic [3:0] dly;
  int n_errors, n_checks, k;
  are_engine uut (.mclk(mclk), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_wait(host_wait),
    .intrq(intrq), .mult_load(mult_load), .mult_size(mult_size), .soft_reset(soft_reset),
    .keep_settings(keep_settings), .med_req(med_req), .med_lba(med_lba), .med_stream(med_stream),
    .med_ack(med_ack), .med_err(med_err), .med_valid(med_valid), .med_ready(med_ready),
    .med_data(med_data));
  are_media_model media (.mclk(mclk), .reset_n(reset_n), .med_req(med_req), .med_lba(med_lba),
    .med_stream(med_stream), .med_ack(med_ack), .med_err(med_err), .med_valid(med_valid),
    .med_ready(med_ready), .med_data(med_data), .err_lba(err_lba), .err_code(err_code), .dly(dly));
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk); host_addr <= a; host_wdata <= {8'h00, v}; host_wr <= 1;
    @(posedge mclk); host_wr <= 0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge mclk); host_addr <= a; host_rd <= 1;
    @(posedge mclk); host_rd <= 0;
    #1 v = host_rdata;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [27:0] l, input logic [7:0] n);
    wr(3'h2, n); wr(3'h3, l[7:0]); wr(3'h4, l[15:8]); wr(3'h5, l[23:16]);
    wr(3'h6, {4'he, l[27:24]});
    wr(3'h7, c);
  endtask
  task automatic wint;
    for (k = 0; intrq !== 1'b1 && k < 20000; k++) @(negedge mclk);
    `CHK(intrq, 1'b1)
  endtask
  task automatic idle; // polls status, which also clears intrq
    k = 0;
    do begin rd(3'h7, d); k++; end while ((d[7] | d[3]) !== 1'b0 && k < 5000);
    `CHK(d[7], 1'b0)
  endtask
  task automatic rdsec(input logic [27:0] l);
    for (int i = 0; i < 256; i++) begin
      for (k = 0; host_wait !== 1'b0 && k < 500; k++) @(negedge mclk);
      rd(3'h0, d);
      `CHK(d, {l[7:0], i[7:0]})
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin mclk = 0; forever #25 mclk = ~mclk; end
  initial begin repeat (40000) @(posedge mclk); n_errors++; end_of_test(); end
  initial begin
    reset_n = 0; host_wr = 0; host_rd = 0; host_addr = 3'h0; host_wdata = 16'h0000;
    mult_load = 0; mult_size = 8'h00; soft_reset = 0; err_lba = 28'hfffffff; err_code = 8'h00;
    dly = 4'h1; n_errors = 0; n_checks = 0; keep_settings = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1;
    rd(3'h7, d); `CHK(d[7:0], 8'h50)
    rd(3'h6, d); `CHK(d[7:0], 8'ha0)
    cmd(8'h20, 28'h0123456, 8'h02);
    wint(); rd(3'h7, d); `CHK(d[7:0], 8'h58)
    rdsec(28'h0123456);
    wint(); rdsec(28'h0123457);
    idle(); rd(3'h3, d); `CHK(d[7:0], 8'h57)
    rd(3'h5, d); `CHK(d[7:0], 8'h12)
    cmd(8'hc4, 28'h10, 8'h03); wint(); rd(3'h1, d); `CHK(d[7:0], 8'h04)
    wr(3'h7, 8'h03); idle(); rd(3'h1, d); `CHK(d[7:0], 8'h1f)
    @(posedge mclk); mult_size <= 8'h02; mult_load <= 1; @(posedge mclk); mult_load <= 0;
    dly <= 4'h9;
    cmd(8'hc4, 28'h10, 8'h03); wint(); rd(3'h7, d); rdsec(28'h10);
    `CHK(host_wait, 1'b1)
    rdsec(28'h11); `CHK(intrq, 1'b0)
    wint(); rdsec(28'h12);
    idle(); rd(3'h3, d); `CHK(d[7:0], 8'h12)
    err_lba <= 28'h21; err_code <= 8'h11;
    cmd(8'h21, 28'h20, 8'h03); wint(); rd(3'h7, d); rdsec(28'h20);
    wint(); rd(3'h7, d); `CHK(d[0], 1'b1)
    rdsec(28'h21); idle(); rd(3'h3, d); `CHK(d[7:0], 8'h21)
    rd(3'h1, d); `CHK(d[7:0], 8'h40)
    cmd(8'h40, 28'h40, 8'h03); wint(); rd(3'h7, d); `CHK(d[7:0], 8'h50)
    rd(3'h3, d); `CHK(d[7:0], 8'h42)
    err_lba <= 28'h41; err_code <= 8'h10;
    cmd(8'h41, 28'h40, 8'h03); wint(); rd(3'h3, d); `CHK(d[7:0], 8'h41)
    rd(3'h1, d); `CHK(d[7:0], 8'h10)
    rd(3'h2, d); `CHK(d[7:0], 8'h02)
    wr(3'h7, 8'h03); idle(); rd(3'h1, d); `CHK(d[7:0], 8'h10)
    wr(3'h7, 8'hef); wr(3'h7, 8'h03); idle(); rd(3'h1, d); `CHK(d[7:0], 8'h20)
    for (int c = 16; c < 32; c++) begin
      wr(3'h7, c[7:0]); idle(); `CHK(d[7:0], 8'h50)
    end
    err_lba <= 28'h61; err_code <= 8'h18;
    cmd(8'h21, 28'h60, 8'h03); wint(); rd(3'h7, d); rdsec(28'h60);
    wint(); rd(3'h7, d); `CHK(d[7:0], 8'h5c)
    rdsec(28'h61); wint(); rdsec(28'h62); idle(); rd(3'h3, d); `CHK(d[7:0], 8'h62)
    wr(3'h7, 8'h03); idle(); rd(3'h1, d); `CHK(d[7:0], 8'h18)
    cmd(8'h40, 28'h100, 8'h00); wint(); rd(3'h3, d); `CHK(d[7:0], 8'hff)
    rd(3'h2, d); `CHK(d[7:0], 8'h00)
    keep_settings <= 1; @(posedge mclk); soft_reset <= 1; @(posedge mclk); soft_reset <= 0;
    cmd(8'hc4, 28'h10, 8'h01); wint(); rd(3'h7, d); `CHK(d[7:0], 8'h58)
    rdsec(28'h10); idle(); keep_settings <= 0;
    @(posedge mclk); soft_reset <= 1; @(posedge mclk); soft_reset <= 0;
    cmd(8'hc4, 28'h10, 8'h01); wint(); rd(3'h1, d); `CHK(d[7:0], 8'h04)
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
